// File: inc/node_regs_pkg.sv
// constants for the usb node state, address and event register block
//
// Overview of operation
// - five-bit tx current trim, resets to 0x10, applied only with diagnostics on
// - diagnostic enable bit 7 opens transceiver diag and trim registers
// - no-crc bit 6 drops trailing crc16 on transmit, receive unchanged
// - short frame bit 5 lets frame timer track short frames
// - address enable bit 7 gates token matching; clear ignores all tokens except address zero with ep0 default-address on
// - ep0 default-address bit makes endpoint 0 answer address zero
// - seven-bit function address matches every token for this device
// - two-bit node state: 00 reset, 01 resume, 10 running, 11 suspend
// - reset state on module reset or software write; disables endpoint pipes
// - resume state drives resume signalling on the bus
// - suspend state puts transceivers into low-power mode
// - suspend entry resets endpoint controllers and tx/last/rx enables
// - bus activity in suspend sets the alternate resume flag
// - event bit 11 sets on charger status change, clears on status read
// - event bit 10 is or of ep0 nak flags, clears on nak read
// - event bit 9 mirrors ep0 receive-last, clears on receive status read
// - event bit 8 mirrors ep0 transmit-done, clears on transmit status read
// - event bit 7 reads zero; mask bit 7 is master interrupt enable
// - a set mask bit enables interrupt for the matching event bit
`default_nettype none
package node_regs_pkg;
   localparam logic [31:0] TRIM_ADDR   = 32'h5000_1804;
   localparam logic [31:0] TEST_ADDR   = 32'h5000_1806;
   localparam logic [31:0] FADDR_ADDR  = 32'h5000_1808;
   localparam logic [31:0] NSTATE_ADDR = 32'h5000_180a;
   localparam logic [31:0] MEVENT_ADDR = 32'h5000_180c;
   localparam logic [31:0] MMASK_ADDR  = 32'h5000_180e;
   // mapping of printed 16-bit offsets onto apb words: offset * 2
   localparam logic [31:0] BASE_ADDR   = 32'h5000_1800;
   localparam logic [4:0]  TRIM_RESET  = 5'h10;
   localparam int          DIAG_BIT    = 7;
   localparam int          NOCRC_BIT   = 6;
   localparam int          SHORTF_BIT  = 5;
   localparam int          ADEN_BIT    = 7;
   localparam int          CHEV_BIT    = 11;
   localparam int          NAKEV_BIT   = 10;
   localparam int          RXEV_BIT    = 9;
   localparam int          TXEV_BIT    = 8;
   localparam int          MIRQ_BIT    = 7;
   typedef enum logic [1:0] {
      STATE_RESET   = 2'h0,
      STATE_WAKEUP  = 2'h1,
      STATE_RUNNING = 2'h2,
      STATE_SLEEP   = 2'h3
   } node_state_t;
   function automatic logic [7:0] word_addr(input logic [31:0] printed);
      return 8'((printed - BASE_ADDR) << 1);
   endfunction
endpackage
`default_nettype wire

// File: hw/usb_node_regs.sv
// apb register block for usb node state, address matching and upper events
`default_nettype none
module usb_node_regs (
   // clock and reset
   input  wire logic                    CLK_SYS,
   input  wire logic                    RESETN,
   // apb slave
   input  wire logic                    PSEL,
   input  wire logic                    PENABLE,
   input  wire logic                    PWRITE,
   input  wire logic [31:0]             PADDR,
   input  wire logic [31:0]             PWDATA,
   output logic      [31:0]             PRDATA,
   output logic                         PREADY,
   output logic                         PSLVERR,
   // node side status inputs (same clock)
   input  wire logic [2:0]              CHARGER_STAT,
   input  wire logic                    CHARGER_RD,
   input  wire logic                    EP0_OUT_NEGACK,
   input  wire logic                    EP0_IN_NEGACK,
   input  wire logic                    EP0_NEGACK_RD,
   input  wire logic                    EP0_RX_LAST,
   input  wire logic                    EP0_RX_STATUS_RD,
   input  wire logic                    EP0_TX_DONE,
   input  wire logic                    EP0_TX_STATUS_RD,
   input  wire logic                    EP0_STD_ADDR_RESPOND,
   input  wire logic                    BUS_ACTIVITY,
   // token address check
   input  wire logic                    TOKEN_VALID,
   input  wire logic [6:0]              TOKEN_ADDR,
   output logic                         TOKEN_MATCH,
   output logic                         TOKEN_EP0_ONLY,
   // transceiver and node controls
   output logic      [4:0]              TX_CURRENT_TRIM,
   output logic                         TRIM_APPLY,
   output logic                         DIAG_ACCESS,
   output logic                         OMIT_TX_CHECKSUM,
   output logic                         SHORT_FRAME_TRACK,
   output node_regs_pkg::node_state_t   NODE_STATE,
   output logic                         RESUME_DRIVE,
   output logic                         XCVR_LOW_POWER,
   output logic                         PIPES_DISABLE,
   output logic                         SLEEP_ENTRY_CLEAR,
   output logic                         WAKE_FLAG_SET,
   output logic                         NODE_IRQ
);
   import node_regs_pkg::*;

   typedef struct packed {
      logic [4:0]  trim;
      logic        diag;
      logic        nocrc;
      logic        shortf;
      logic [4:0]  test_res;
      logic        aden;
      logic [6:0]  faddr;
      node_state_t nstate;
      logic        chev;
      logic [2:0]  chg_last;
      logic        nakev;
      logic        rxev;
      logic        txev;
      logic [4:0]  mask;
      logic        mirq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        match;
      logic        ep0only;
      logic        sleep_clr;
      logic        wake_set;
      logic        irq;
   } regs_t;

   regs_t st_r;
   regs_t st_nxt;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic        acc;
      logic        wr;
      logic        rd;
      logic [7:0]  idx;
      logic [15:0] rval;
      logic        hit;
      logic [15:0] ev;
      st_nxt = st_r;
      acc  = PSEL && PENABLE && !st_r.pready;
      wr   = acc && PWRITE;
      rd   = acc && !PWRITE;
      idx  = PADDR[7:0];
      hit  = (PADDR[31:8] == BASE_ADDR[31:8]) && (PADDR[1:0] == 2'h0);
      rval = 16'h0000;
      st_nxt.pready    = acc;
      st_nxt.pslverr   = 1'b0;
      st_nxt.sleep_clr = 1'b0;
      st_nxt.wake_set  = 1'b0;

      ev = 16'h0000;
      ev[CHEV_BIT]  = st_r.chev;
      ev[NAKEV_BIT] = st_r.nakev;
      ev[RXEV_BIT]  = st_r.rxev;
      ev[TXEV_BIT]  = st_r.txev;
      // bit 7 of the event word stays zero
      ev[MIRQ_BIT]  = 1'b0;

      case (idx)
         word_addr(TRIM_ADDR):
            rval = {11'h000, st_r.trim};
         word_addr(TEST_ADDR):
            rval = {8'h00, st_r.diag, st_r.nocrc, st_r.shortf, st_r.test_res};
         word_addr(FADDR_ADDR):
            rval = {8'h00, st_r.aden, st_r.faddr};
         word_addr(NSTATE_ADDR):
            rval = {14'h0000, st_r.nstate};
         word_addr(MEVENT_ADDR):
            rval = ev;
         word_addr(MMASK_ADDR):
            rval = {4'h0, st_r.mask[3:0], st_r.mirq, 7'h00};
         default: begin
            rval = 16'h0000;
            hit  = 1'b0;
         end
      endcase
      if (acc) begin
         st_nxt.prdata  = rd ? {16'h0000, rval} : 32'h0000_0000;
         st_nxt.pslverr = !hit;
      end

      if (wr && hit) begin
         case (idx)
            word_addr(TRIM_ADDR): begin
               // trim only writable once diagnostics are open
               if (st_r.diag) begin
                  st_nxt.trim = PWDATA[4:0];
               end
            end
            word_addr(TEST_ADDR): begin
               st_nxt.diag     = PWDATA[DIAG_BIT];
               st_nxt.nocrc    = PWDATA[NOCRC_BIT];
               st_nxt.shortf   = PWDATA[SHORTF_BIT];
               // stored as written so misuse stays visible on readback
               st_nxt.test_res = PWDATA[4:0];
            end
            word_addr(FADDR_ADDR): begin
               st_nxt.aden  = PWDATA[ADEN_BIT];
               st_nxt.faddr = PWDATA[6:0];
            end
            word_addr(NSTATE_ADDR): begin
               st_nxt.nstate = node_state_t'(PWDATA[1:0]);
               if (node_state_t'(PWDATA[1:0]) == STATE_SLEEP &&
                   st_r.nstate != STATE_SLEEP) begin
                  st_nxt.sleep_clr = 1'b1;
               end
            end
            word_addr(MMASK_ADDR): begin
               st_nxt.mask = {1'b0, PWDATA[11:8]};
               st_nxt.mirq = PWDATA[MIRQ_BIT];
            end
            default: begin
               st_nxt.mask = st_r.mask;
            end
         endcase
      end

      // charger change: set wins over the read clear
      st_nxt.chg_last = CHARGER_STAT;
      if (CHARGER_STAT != st_r.chg_last) begin
         st_nxt.chev = 1'b1;
      end else if (CHARGER_RD) begin
         st_nxt.chev = 1'b0;
      end
      // ep0 events follow their source flags; a read clears them
      // unless the source is still raising the same cycle
      if (EP0_OUT_NEGACK || EP0_IN_NEGACK) begin
         st_nxt.nakev = 1'b1;
      end else if (EP0_NEGACK_RD) begin
         st_nxt.nakev = 1'b0;
      end
      if (EP0_RX_LAST) begin
         st_nxt.rxev = 1'b1;
      end else if (EP0_RX_STATUS_RD) begin
         st_nxt.rxev = 1'b0;
      end
      if (EP0_TX_DONE) begin
         st_nxt.txev = 1'b1;
      end else if (EP0_TX_STATUS_RD) begin
         st_nxt.txev = 1'b0;
      end

      if (st_r.nstate == STATE_SLEEP && BUS_ACTIVITY) begin
         st_nxt.wake_set = 1'b1;
      end

      // token matching is blocked while the node is held in reset
      st_nxt.match   = 1'b0;
      st_nxt.ep0only = 1'b0;
      if (TOKEN_VALID && st_r.nstate != STATE_RESET) begin
         if (st_r.aden && TOKEN_ADDR == st_r.faddr) begin
            st_nxt.match = 1'b1;
         end else if (EP0_STD_ADDR_RESPOND && TOKEN_ADDR == 7'h00) begin
            st_nxt.match   = 1'b1;
            st_nxt.ep0only = 1'b1;
         end
      end

      st_nxt.irq = st_nxt.mirq &&
                   ((st_nxt.chev  && st_nxt.mask[3]) ||
                    (st_nxt.nakev && st_nxt.mask[2]) ||
                    (st_nxt.rxev  && st_nxt.mask[1]) ||
                    (st_nxt.txev  && st_nxt.mask[0]));
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         st_r          <= '0;
         st_r.trim     <= TRIM_RESET;
         st_r.nstate   <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all registered
   // -----------------------------------------------------------------
   logic pipes_r;
   logic resume_r;
   logic lowpwr_r;
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         pipes_r  <= 1'b1;
         resume_r <= 1'b0;
         lowpwr_r <= 1'b0;
      end else begin
         pipes_r  <= (st_nxt.nstate == STATE_RESET);
         resume_r <= (st_nxt.nstate == STATE_WAKEUP);
         lowpwr_r <= (st_nxt.nstate == STATE_SLEEP);
      end
   end

   assign PRDATA            = st_r.prdata;
   assign PREADY            = st_r.pready;
   assign PSLVERR           = st_r.pslverr;
   assign TOKEN_MATCH       = st_r.match;
   assign TOKEN_EP0_ONLY    = st_r.ep0only;
   assign TX_CURRENT_TRIM   = st_r.trim;
   assign TRIM_APPLY        = st_r.diag;
   assign DIAG_ACCESS       = st_r.diag;
   assign OMIT_TX_CHECKSUM  = st_r.nocrc;
   assign SHORT_FRAME_TRACK = st_r.shortf;
   assign NODE_STATE        = st_r.nstate;
   assign RESUME_DRIVE      = resume_r;
   assign XCVR_LOW_POWER    = lowpwr_r;
   assign PIPES_DISABLE     = pipes_r;
   assign SLEEP_ENTRY_CLEAR = st_r.sleep_clr;
   assign WAKE_FLAG_SET     = st_r.wake_set;
   assign NODE_IRQ          = st_r.irq;
endmodule
`default_nettype wire

// File: tb/usb_node_regs_sva.sv
// port assertions for the usb node register block
`default_nettype none
module usb_node_regs_sva (
   // watched ports
   input wire logic                       CLK_SYS,
   input wire logic                       RESETN,
   input wire logic                       TOKEN_VALID,
   input wire logic                       TOKEN_MATCH,
   input wire logic                       BUS_ACTIVITY,
   input wire node_regs_pkg::node_state_t NODE_STATE,
   input wire logic                       TRIM_APPLY,
   input wire logic [4:0]                 TX_CURRENT_TRIM,
   input wire logic                       DIAG_ACCESS,
   input wire logic                       RESUME_DRIVE,
   input wire logic                       XCVR_LOW_POWER,
   input wire logic                       PIPES_DISABLE,
   input wire logic                       SLEEP_ENTRY_CLEAR,
   input wire logic                       WAKE_FLAG_SET
);
   import node_regs_pkg::*;
   // ------------------------------------------------------------
   // decodes are checked only once the source settled a cycle
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);
   a_trim_apply: assert property (!$stable(TX_CURRENT_TRIM) |->
      $past(DIAG_ACCESS)) else $error("trim changed with diag off");
   a_resume_drive: assert property ($stable(NODE_STATE) |->
      RESUME_DRIVE == (NODE_STATE == STATE_WAKEUP)) else $error("resume");
   a_low_power: assert property ($stable(NODE_STATE) |->
      XCVR_LOW_POWER == (NODE_STATE == STATE_SLEEP)) else $error("lowpwr");
   a_pipes_off: assert property ($stable(NODE_STATE) |->
      PIPES_DISABLE == (NODE_STATE == STATE_RESET)) else $error("pipes");
   a_wake_flag: assert property (BUS_ACTIVITY &&
      NODE_STATE == STATE_SLEEP |-> ##[1:2] WAKE_FLAG_SET)
      else $error("wake flag missing");
   a_sleep_entry: assert property (SLEEP_ENTRY_CLEAR |->
      ##[0:1] XCVR_LOW_POWER) else $error("sleep clear outside sleep");
   a_no_match_rst: assert property (TOKEN_VALID &&
      NODE_STATE == STATE_RESET && $stable(NODE_STATE) |=> !TOKEN_MATCH)
      else $error("token matched in reset");
   a_match_cause: assert property (TOKEN_MATCH |->
      $past(TOKEN_VALID) || $past(TOKEN_VALID, 2))
      else $error("match without token");
   cover property (SLEEP_ENTRY_CLEAR);
   cover property (WAKE_FLAG_SET);
   cover property (TOKEN_MATCH);
endmodule
bind usb_node_regs usb_node_regs_sva sva_i (.CLK_SYS, .RESETN,
   .TOKEN_VALID, .TOKEN_MATCH, .BUS_ACTIVITY, .NODE_STATE, .TRIM_APPLY,
   .TX_CURRENT_TRIM,
   .DIAG_ACCESS, .RESUME_DRIVE, .XCVR_LOW_POWER, .PIPES_DISABLE,
   .SLEEP_ENTRY_CLEAR, .WAKE_FLAG_SET);
`default_nettype wire

// File: tb/usb_host_model.sv
// behavioural host side: tokens and bus activity
`default_nettype none
module usb_host_model (
   // bus side
   input  wire logic       clk,
   output logic            tok_valid,
   output logic      [6:0] tok_addr,
   output logic            bus_act
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tok_valid = 1'b0;
      tok_addr = 7'h7f;
      bus_act = 1'b0;
   end
   // a released address shows its inverse so stale values never match
   task automatic token(input logic [6:0] a);
      tok_valid <= 1'b1;
      tok_addr <= a;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok_addr <= ~a;
   endtask
   task automatic wake();
      bus_act <= 1'b1;
      @(posedge clk);
      bus_act <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/usb_node_state_address_events_tb.sv
// self-checking bench for the usb node register block
`default_nettype none
module usb_node_state_address_events_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import node_regs_pkg::*;
   // ------------------------------------------------------------
   // bench state and instances
   // ------------------------------------------------------------
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, std = 0;
   logic [31:0] padr = 0, pwd = 0, prd, r;
   logic [4:0]  src = 0, trim;
   logic [3:0]  rdp = 0;
   logic [6:0]  ta;
   logic        prdy, perr, e, tv, tm, act, tap, dga, omc, sft;
   logic        res, lpw, pdis, irq, ep0o, eo, sec, wfs;
   logic        sec_seen = 0, wfs_seen = 0;
   node_state_t nst;
   int          num_errors = 0, tests_run = 0, cyc = 0;
   always #10 clk = ~clk;
   usb_node_regs dut (.CLK_SYS(clk), .RESETN(rstn), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
      .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
      .CHARGER_STAT({2'b00, src[3]}), .CHARGER_RD(rdp[3]),
      .EP0_OUT_NEGACK(src[2]), .EP0_IN_NEGACK(src[4]),
      .EP0_NEGACK_RD(rdp[2]), .EP0_RX_LAST(src[1]),
      .EP0_RX_STATUS_RD(rdp[1]), .EP0_TX_DONE(src[0]),
      .EP0_TX_STATUS_RD(rdp[0]), .EP0_STD_ADDR_RESPOND(std),
      .BUS_ACTIVITY(act), .TOKEN_VALID(tv), .TOKEN_ADDR(ta),
      .TOKEN_MATCH(tm), .TOKEN_EP0_ONLY(ep0o), .TX_CURRENT_TRIM(trim),
      .TRIM_APPLY(tap), .DIAG_ACCESS(dga), .OMIT_TX_CHECKSUM(omc),
      .SHORT_FRAME_TRACK(sft), .NODE_STATE(nst), .RESUME_DRIVE(res),
      .XCVR_LOW_POWER(lpw), .PIPES_DISABLE(pdis),
      .SLEEP_ENTRY_CLEAR(sec), .WAKE_FLAG_SET(wfs), .NODE_IRQ(irq));
   // one-cycle pulses are latched so a scenario can judge them later
   always @(posedge clk) begin
      if (sec)
         sec_seen <= 1'b1;
      if (wfs)
         wfs_seen <= 1'b1;
   end
   usb_host_model host (.clk(clk), .tok_valid(tv), .tok_addr(ta),
      .bus_act(act));
   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] x);
      tests_run++;
      if (got !== x) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, x);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // registers sit at twice their printed distance from the base
   function automatic logic [31:0] wa(input logic [31:0] p);
      return BASE_ADDR + ((p - BASE_ADDR) << 1);
   endfunction
   task automatic apb(input logic w, input logic [31:0] a, d);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [31:0] a, d);
      apb(1'b1, wa(a), d);
   endtask
   task automatic rdc(input logic [31:0] a, x);
      apb(1'b0, wa(a), 32'h0);
      chk(r, x);
   endtask
   // the match may land one or two edges after the token
   task automatic tok(input logic [6:0] a, input logic x);
      logic m;
      host.token(a);
      #1 m = tm;
      eo = ep0o;
      @(posedge clk);
      #1 m = m | tm;
      eo = eo | ep0o;
      @(posedge clk);
      chk(m, x);
   endtask
   task automatic t_reset();
      chk(trim, 5'h10);
      chk(pdis, 1'b1);
      rdc(TRIM_ADDR, 32'h10);
      rdc(NSTATE_ADDR, 32'h0);
      apb(1'b1, BASE_ADDR + 32'h40, 32'h1);
      chk(e, 1'b1);
   endtask
   task automatic t_diag();
      wr(TRIM_ADDR, 32'h05);
      rdc(TRIM_ADDR, 32'h10);
      wr(TEST_ADDR, 32'h80);
      tick(2);
      chk({dga, tap}, 2'b11);
      wr(TRIM_ADDR, 32'h05);
      tick(2);
      chk(trim, 5'h05);
      wr(TEST_ADDR, 32'h60);
      tick(2);
      chk({dga, omc, sft}, 3'b011);
   endtask
   task automatic t_tokens();
      wr(FADDR_ADDR, 32'haa);
      wr(NSTATE_ADDR, 32'h2);
      tok(7'h2a, 1'b1);
      chk(eo, 1'b0);
      tok(7'h2b, 1'b0);
      std <= 1'b1;
      tok(7'h00, 1'b1);
      chk(eo, 1'b1);
      wr(FADDR_ADDR, 32'h2a);
      tok(7'h2a, 1'b0);
      wr(FADDR_ADDR, 32'haa);
      wr(NSTATE_ADDR, 32'h0);
      tok(7'h2a, 1'b0);
      std <= 1'b0;
      wr(FADDR_ADDR, 32'h0);
   endtask
   task automatic t_states();
      for (int s = 0; s < 4; s++) begin
         wr(NSTATE_ADDR, s);
         if (s == 1)
            tick(50000);
         tick(2);
         rdc(NSTATE_ADDR, s);
         chk({res, lpw, pdis}, {s == 1, s == 3, s == 0});
         chk(sec_seen, s == 3);
      end
      chk(wfs_seen, 1'b0);
      host.wake();
      tick(2);
      chk(wfs_seen, 1'b1);
   endtask
   task automatic t_events();
      wr(MMASK_ADDR, 32'hf80);
      wr(MEVENT_ADDR, 32'hffff);
      rdc(MEVENT_ADDR, 32'h0);
      for (int i = 0; i < 5; i++) begin
         src[i] <= 1'b1;
         tick(3);
         chk(irq, 1'b1);
         rdc(MEVENT_ADDR, 32'h1 << (i == 4 ? 10 : 8 + i));
         if (i != 3)
            src[i] <= 1'b0;
         rdp[i == 4 ? 2 : i] <= 1'b1;
         tick(1);
         rdp <= 4'h0;
         tick(2);
         rdc(MEVENT_ADDR, 32'h0);
         chk(irq, 1'b0);
      end
      wr(MMASK_ADDR, 32'hf00);
      src[0] <= 1'b1;
      tick(3);
      chk(irq, 1'b0);
      wr(MMASK_ADDR, 32'he80);
      tick(2);
      chk(irq, 1'b0);
      wr(MMASK_ADDR, 32'hf80);
      tick(2);
      chk(irq, 1'b1);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_diag();
      t_tokens();
      t_states();
      t_events();
      summarize();
   end
endmodule
`default_nettype wire
